//--- src/sarsq_cfg.svh
`ifndef SARSQ_CFG_SVH
`define SARSQ_CFG_SVH
// What this block does
// - sample-hold ticks then ten conversion ticks
// - conversion clock is bus clock over 2..128
// - reset to 10-bit; low-res zeroes top bits
// - dma size 16-bit, 8-bit in low-res
// - done result goes to channel, last, flags
// - dma request on each data-ready rise
// - masked done or ready flags raise interrupt
// - channel data reads clear done; last result read clears done and ready
// - unread channel result overwritten sets overrun
// - new result while ready sets global overrun
// - status read clears all overrun flags
// - start bit write launches a sequence
// - selected hardware trigger rising edge starts
// - software start still works with hardware
// - one trigger converts all enabled, idles
// - enable and disable writes set channel state
// - dma only for enabled channel results
// - sleep: wake, wait, convert, power down
// - sleep: triggers during a sequence ignored
// - hold sample for field plus one ticks
// - wake wait is field plus one times eight
// - trigger enable low ignores hardware triggers

// register byte offsets
`define SARSQ_OFS_CMD 8'h00
`define SARSQ_OFS_CFG 8'h04
`define SARSQ_OFS_CHEN 8'h10
`define SARSQ_OFS_CHDIS 8'h14
`define SARSQ_OFS_CHSTAT 8'h18
`define SARSQ_OFS_FLAGS 8'h1C
`define SARSQ_OFS_LAST 8'h20
`define SARSQ_OFS_IEN 8'h24
`define SARSQ_OFS_IDIS 8'h28
`define SARSQ_OFS_IMASK 8'h2C
`define SARSQ_OFS_CDR0 8'h30
// command bits
`define SARSQ_CMD_SWRST 0
`define SARSQ_CMD_START 1
// config fields
`define SARSQ_CFG_HW_TRIGGER_ENABLE 0
`define SARSQ_CFG_HW_TRIGGER_SELECT_LSB 1
`define SARSQ_CFG_LOW_RESOLUTION_SELECT 4
`define SARSQ_CFG_SLEEP 5
`define SARSQ_CFG_DIV_LSB 8
`define SARSQ_CFG_SU_LSB 16
`define SARSQ_CFG_SH_LSB 24
`define SARSQ_CFG_MASK 32'h0F7F3F3F
`define SARSQ_CFG_RESET 32'h00000000
// status fields
`define SARSQ_SR_OVRE_LSB 8
`define SARSQ_SR_RESULT_READY_FLAG 16
`define SARSQ_SR_GLOBAL_OVERRUN_FLAG 17
// timing, in conversion clock ticks, and the external trigger select code
`define SARSQ_CONV_TICKS 10'h00A
`define SARSQ_TRG_EXT 3'h6
`endif

//--- src/sarsq_ctrl.sv
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "sarsq_cfg.svh"
module sarsq_ctrl #(
  parameter int NCH = 8
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic [5:0] timer_waveform_output,
  input wire logic ext_trigger,
  output logic cell_power_on,
  output logic cell_clk_en,
  output logic conv_tick,
  output logic [$clog2(NCH)-1:0] cell_channel,
  output logic cell_sample,
  output logic cell_convert,
  input wire logic [9:0] cell_result,
  output logic dma_req,
  output logic dma_size_8bit,
  output logic irq
);
  localparam int CHW = $clog2(NCH);

  // lowest enabled channel at or above from; msb says one was found
  function automatic logic [CHW:0] next_chan(input logic [NCH-1:0] mask,
                                             input logic [CHW:0] from);
    logic [CHW:0] r;
    r = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (mask[i] && i >= int'(from)) r = {1'b1, i[CHW-1:0]};
    end
    return r;
  endfunction

  // command decode: pulses only, nothing stored
  logic wr_cmd;
  logic sw_reset;
  logic sw_start;
  logic clr; // hard or software reset
  assign wr_cmd = reg_write && (reg_addr == `SARSQ_OFS_CMD);
  assign sw_reset = wr_cmd && reg_wdata[`SARSQ_CMD_SWRST];
  assign sw_start = wr_cmd && reg_wdata[`SARSQ_CMD_START];
  assign clr = reset || sw_reset;

  // mode word
  logic [31:0] config_reg;
  always_ff @(posedge core_clk) begin
    if (clr) begin
      config_reg <= `SARSQ_CFG_RESET;
    end else if (reg_write && reg_addr == `SARSQ_OFS_CFG) begin
      config_reg <= reg_wdata & `SARSQ_CFG_MASK;
    end
  end

  logic [3:0] sample_hold_cycles;
  logic [6:0] startup_field;
  logic [5:0] conv_clock_divider;
  assign sample_hold_cycles = config_reg[`SARSQ_CFG_SH_LSB +: 4];
  assign startup_field = config_reg[`SARSQ_CFG_SU_LSB +: 7];
  assign conv_clock_divider = config_reg[`SARSQ_CFG_DIV_LSB +: 6];

  // channel enable state, set and clear by separate writes
  logic [NCH-1:0] chan_en_reg;
  always_ff @(posedge core_clk) begin
    if (clr) begin
      chan_en_reg <= '0;
    end else if (reg_write && reg_addr == `SARSQ_OFS_CHEN) begin
      chan_en_reg <= chan_en_reg | reg_wdata[NCH-1:0];
    end else if (reg_write && reg_addr == `SARSQ_OFS_CHDIS) begin
      chan_en_reg <= chan_en_reg & ~reg_wdata[NCH-1:0];
    end
  end

  // trigger synchronisers; stage 3 only feeds the edge detector
  logic [6:0] trg_s1_reg;
  logic [6:0] trg_s2_reg;
  logic [6:0] trg_s3_reg;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      trg_s1_reg <= '0;
      trg_s2_reg <= '0;
      trg_s3_reg <= '0;
    end else begin
      trg_s1_reg <= {ext_trigger, timer_waveform_output};
      trg_s2_reg <= trg_s1_reg;
      trg_s3_reg <= trg_s2_reg;
    end
  end

  // sequencer state
  sarsq_pkg::sarsq_state_e state_reg;
  logic [CHW-1:0] ch_reg; // channel being converted
  logic [9:0] tmr_reg; // ticks spent in the current state
  logic [NCH-1:0] cap_en_reg;
  logic cap_low_resolution_select_reg;
  logic cap_sleep_reg;
  logic cap_hw_trigger_enable_reg;
  logic [2:0] cap_sel_reg;
  logic pend_reg; // normal mode start seen while busy
  logic busy;
  assign busy = state_reg != sarsq_pkg::sarsq_idle;

  // trigger selection follows the captured settings while busy
  logic act_hw_trigger_enable;
  logic [2:0] act_sel;
  logic hw_edge;
  logic start_req;
  logic go;
  assign act_hw_trigger_enable = busy ? cap_hw_trigger_enable_reg : config_reg[`SARSQ_CFG_HW_TRIGGER_ENABLE];
  assign act_sel = busy ? cap_sel_reg : config_reg[`SARSQ_CFG_HW_TRIGGER_SELECT_LSB +: 3];
  // code 7 selects nothing; trigger enable low masks all hardware edges
  assign hw_edge = act_hw_trigger_enable && act_sel <= `SARSQ_TRG_EXT &&
                   trg_s2_reg[act_sel] && !trg_s3_reg[act_sel];
  assign start_req = sw_start || hw_edge;
  assign go = !busy && (start_req || pend_reg);

  // conversion clock divider: one tick every (div+1)*2 bus cycles
  logic [6:0] div_cnt_reg;
  logic tick;
  assign tick = busy && div_cnt_reg == {conv_clock_divider, 1'b1};
  always_ff @(posedge core_clk) begin
    if (clr || !busy || tick) begin
      div_cnt_reg <= '0; // stopped while idle
    end else begin
      div_cnt_reg <= div_cnt_reg + 7'h01;
    end
  end

  logic [CHW:0] first_ch;
  logic [CHW:0] nxt_ch;
  logic conv_done;
  assign first_ch = next_chan(chan_en_reg, '0);
  assign nxt_ch = next_chan(cap_en_reg, (CHW+1)'({1'b0, ch_reg} + 1'b1));
  assign conv_done = state_reg == sarsq_pkg::sarsq_conv && tick &&
                     tmr_reg == `SARSQ_CONV_TICKS - 10'h001;

  // sequence walk
  always_ff @(posedge core_clk) begin
    if (clr) begin
      state_reg <= sarsq_pkg::sarsq_idle;
      ch_reg <= '0;
      tmr_reg <= '0;
    end else begin
      unique case (state_reg)
        sarsq_pkg::sarsq_idle: begin
          // an empty channel set simply swallows the start
          if (go && first_ch[CHW]) begin
            ch_reg <= first_ch[CHW-1:0];
            tmr_reg <= '0;
            state_reg <= config_reg[`SARSQ_CFG_SLEEP] ? sarsq_pkg::sarsq_wake
                                                      : sarsq_pkg::sarsq_hold;
          end
        end
        sarsq_pkg::sarsq_wake: begin
          // cell start-up wait, (field+1)*8 ticks
          if (tick) begin
            if (tmr_reg == {startup_field, 3'h7}) begin
              tmr_reg <= '0;
              state_reg <= sarsq_pkg::sarsq_hold;
            end else begin
              tmr_reg <= tmr_reg + 10'h001;
            end
          end
        end
        sarsq_pkg::sarsq_hold: begin
          if (tick) begin
            if (tmr_reg == {6'h00, sample_hold_cycles}) begin
              tmr_reg <= '0;
              state_reg <= sarsq_pkg::sarsq_conv;
            end else begin
              tmr_reg <= tmr_reg + 10'h001;
            end
          end
        end
        sarsq_pkg::sarsq_conv: begin
          if (conv_done) begin
            tmr_reg <= '0;
            if (nxt_ch[CHW]) begin
              ch_reg <= nxt_ch[CHW-1:0];
              state_reg <= sarsq_pkg::sarsq_hold;
            end else begin
              state_reg <= sarsq_pkg::sarsq_idle;
            end
          end else if (tick) begin
            tmr_reg <= tmr_reg + 10'h001;
          end
        end
      endcase
    end
  end

  // channel set, resolution, sleep and trigger settings frozen for the whole sequence
  always_ff @(posedge core_clk) begin
    if (clr) begin
      cap_en_reg <= '0;
      cap_low_resolution_select_reg <= 1'b0;
      cap_sleep_reg <= 1'b0;
      cap_hw_trigger_enable_reg <= 1'b0;
      cap_sel_reg <= '0;
    end else if (go) begin
      cap_en_reg <= chan_en_reg;
      cap_low_resolution_select_reg <= config_reg[`SARSQ_CFG_LOW_RESOLUTION_SELECT];
      cap_sleep_reg <= config_reg[`SARSQ_CFG_SLEEP];
      cap_hw_trigger_enable_reg <= config_reg[`SARSQ_CFG_HW_TRIGGER_ENABLE];
      cap_sel_reg <= config_reg[`SARSQ_CFG_HW_TRIGGER_SELECT_LSB +: 3];
    end
  end

  // normal mode remembers one start during a sequence; sleep mode drops it
  always_ff @(posedge core_clk) begin
    if (clr || !busy) begin
      pend_reg <= 1'b0;
    end else if (start_req && !cap_sleep_reg) begin
      pend_reg <= 1'b1;
    end
  end

  // result storage
  logic [9:0] result_val;
  logic [9:0] chan_data_reg [NCH];
  logic [9:0] last_data_reg;
  logic [CHW-1:0] last_ch_reg;
  assign result_val = cap_low_resolution_select_reg ? {2'b00, cell_result[9:2]} : cell_result;
  always_ff @(posedge core_clk) begin
    if (clr) begin
      for (int i = 0; i < NCH; i++) chan_data_reg[i] <= '0;
      last_data_reg <= '0;
      last_ch_reg <= '0;
    end else if (conv_done) begin
      chan_data_reg[ch_reg] <= result_val;
      last_data_reg <= result_val;
      last_ch_reg <= ch_reg;
    end
  end

  // read side effects
  logic [7:0] cdr_off;
  logic cdr_hit;
  logic rd_last;
  logic rd_sr;
  assign cdr_off = reg_addr - `SARSQ_OFS_CDR0;
  assign cdr_hit = reg_addr >= `SARSQ_OFS_CDR0 && int'(cdr_off[7:2]) < NCH &&
                   cdr_off[1:0] == 2'b00;
  assign rd_last = reg_read && reg_addr == `SARSQ_OFS_LAST;
  assign rd_sr = reg_read && reg_addr == `SARSQ_OFS_FLAGS;

  // flags: a new result always beats a same-cycle read clear
  logic [NCH-1:0] eoc_reg;
  logic [NCH-1:0] ovre_reg;
  logic result_ready_flag_reg;
  logic global_overrun_flag_reg;
  logic [NCH-1:0] eoc_clr;
  logic [NCH-1:0] done_hot;
  logic result_ready_flag_next;
  always_comb begin
    eoc_clr = '0;
    done_hot = '0;
    if (reg_read && cdr_hit) eoc_clr[cdr_off[2 +: CHW]] = 1'b1;
    if (rd_last) eoc_clr[last_ch_reg] = 1'b1;
    if (conv_done) done_hot[ch_reg] = 1'b1;
  end
  assign result_ready_flag_next = conv_done || (result_ready_flag_reg && !rd_last);
  always_ff @(posedge core_clk) begin
    if (clr) begin
      eoc_reg <= '0;
      ovre_reg <= '0;
      result_ready_flag_reg <= 1'b0;
      global_overrun_flag_reg <= 1'b0;
    end else begin
      eoc_reg <= (eoc_reg & ~eoc_clr) | done_hot;
      result_ready_flag_reg <= result_ready_flag_next;
      ovre_reg <= (ovre_reg & ~{NCH{rd_sr}}) | (done_hot & eoc_reg);
      global_overrun_flag_reg <= (global_overrun_flag_reg && !rd_sr) || (conv_done && result_ready_flag_reg);
    end
  end

  // dma: one request per data-ready rise, enabled channels only
  always_ff @(posedge core_clk) begin
    if (clr) begin
      dma_req <= 1'b0;
    end else begin
      dma_req <= result_ready_flag_next && !result_ready_flag_reg && cap_en_reg[ch_reg];
    end
  end
  assign dma_size_8bit = cap_low_resolution_select_reg;

  // interrupt mask and request
  logic [31:0] sr_val;
  logic [17:0] imask_reg;
  always_comb begin
    sr_val = '0;
    sr_val[NCH-1:0] = eoc_reg;
    sr_val[`SARSQ_SR_OVRE_LSB +: NCH] = ovre_reg;
    sr_val[`SARSQ_SR_RESULT_READY_FLAG] = result_ready_flag_reg;
    sr_val[`SARSQ_SR_GLOBAL_OVERRUN_FLAG] = global_overrun_flag_reg;
  end
  always_ff @(posedge core_clk) begin
    if (clr) begin
      imask_reg <= '0;
      irq <= 1'b0;
    end else begin
      if (reg_write && reg_addr == `SARSQ_OFS_IEN) imask_reg <= imask_reg | reg_wdata[17:0];
      if (reg_write && reg_addr == `SARSQ_OFS_IDIS) imask_reg <= imask_reg & ~reg_wdata[17:0];
      irq <= |(sr_val[17:0] & imask_reg);
    end
  end

  // read mux; write-only and unmapped words read zero
  logic [31:0] rd_val;
  always_comb begin
    case (reg_addr)
      `SARSQ_OFS_CFG: rd_val = config_reg;
      `SARSQ_OFS_CHSTAT: rd_val = 32'(chan_en_reg);
      `SARSQ_OFS_FLAGS: rd_val = sr_val;
      `SARSQ_OFS_LAST: rd_val = {22'h000000, last_data_reg};
      `SARSQ_OFS_IMASK: rd_val = {14'h0000, imask_reg};
      default: rd_val = cdr_hit ? {22'h000000, chan_data_reg[cdr_off[2 +: CHW]]} : '0;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_read ? rd_val : '0; // valid only the cycle after the strobe
    end
  end

  // analog cell controls; sleep mode powers the cell only while busy
  assign cell_power_on = busy || !config_reg[`SARSQ_CFG_SLEEP];
  assign cell_clk_en = busy;
  assign conv_tick = tick;
  assign cell_channel = ch_reg;
  assign cell_sample = state_reg == sarsq_pkg::sarsq_hold;
  assign cell_convert = state_reg == sarsq_pkg::sarsq_conv;

  default clocking @(posedge core_clk); endclocking
  default disable iff (clr);

  chk_tick_spacing: assert property (tick |=> !tick)
    else $error("conversion ticks back to back");
  chk_conv_ten: assert property (
    (cell_convert && tick && tmr_reg < 10'h009) |=> cell_convert)
    else $error("conversion left before ten ticks");
  chk_hold_len: assert property (
    (cell_sample && tick && tmr_reg == {6'h00, sample_hold_cycles}) |=> cell_convert)
    else $error("hold phase length wrong");
  chk_wake_len: assert property (
    (state_reg == sarsq_pkg::sarsq_wake && tick && tmr_reg == {startup_field, 3'h7})
    |=> cell_sample)
    else $error("start-up wait length wrong");
  chk_low_resolution_select_zero: assert property (
    (conv_done && cap_low_resolution_select_reg) |=> last_data_reg[9:8] == 2'b00)
    else $error("low resolution top bits not zero");
  chk_store_done: assert property (
    conv_done |=> result_ready_flag_reg && eoc_reg[$past(ch_reg)] && last_data_reg == $past(result_val))
    else $error("result or flags not stored");
  chk_dma_rise: assert property (dma_req |-> result_ready_flag_reg && !$past(result_ready_flag_reg))
    else $error("dma request without data-ready rise");
  chk_last_clear: assert property ((rd_last && !conv_done) |=> !result_ready_flag_reg)
    else $error("last result read kept data-ready");
  chk_sr_clear: assert property ((rd_sr && !conv_done) |=> ovre_reg == '0 && !global_overrun_flag_reg)
    else $error("status read kept overrun");
  chk_seq_end: assert property ((conv_done && !nxt_ch[CHW]) |=> !busy)
    else $error("sequence did not return to idle");
  chk_irq_mask: assert property (irq |-> $past(|(sr_val[17:0] & imask_reg)))
    else $error("interrupt without masked flag");

  cov_sleep_conv: cover property (conv_done && cap_sleep_reg);
  cov_dma: cover property (dma_req);
  cov_global_overrun_flag: cover property ($rose(global_overrun_flag_reg));
  cov_hw_start: cover property (go && hw_edge);
endmodule
`default_nettype wire

//--- src/sarsq_pkg.sv
package sarsq_pkg;
  // sequencer states
  typedef enum logic [1:0] {
    sarsq_idle = 2'b00,
    sarsq_wake = 2'b01,
    sarsq_hold = 2'b10,
    sarsq_conv = 2'b11
  } sarsq_state_e;
endpackage

//--- tb/sarsq_cell_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural analog cell: the code it returns is built from the channel and a bench value
module sarsq_cell_model (
  input wire logic core_clk,
  input wire logic cell_convert,
  input wire logic [2:0] cell_channel,
  input wire logic [6:0] seed,
  output logic [9:0] cell_result
);
  logic [9:0] last_reg = 10'h000; // code shown in the previous cycle
  // remember what was shown so an idle output can move away from it
  always_ff @(posedge core_clk) begin
    last_reg <= cell_result;
  end
  // outside conversion the output is not held: inverse of last, so a late sample shows up
  assign cell_result = cell_convert ? {cell_channel, seed} : ~last_reg;
endmodule
`default_nettype wire

//--- tb/sarsq_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "sarsq_cfg.svh"
`define CHK(nm, e, g) begin comparisons++; if ((e) !== (g)) begin n_fail++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module sarsq_ctrl_test;
  typedef struct packed {logic [2:0] ch; logic [7:0] shk; logic [15:0] cyc;} sarsq_ph_s;
  logic core_clk = 1'b0; // 40 MHz
  logic reset = 1'b1; // held for three cycles
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic [5:0] timer_waveform_output = 6'h00;
  logic ext_trigger = 1'b0;
  logic cell_power_on, cell_clk_en, conv_tick, cell_sample, cell_convert;
  logic [2:0] cell_channel;
  logic [9:0] cell_result, c;
  logic dma_req, dma_size_8bit, irq;
  logic [6:0] sv = 7'h00; // code seed fed to the cell model
  integer seed = 32'h42320E13;
  int n_fail = 0;
  int comparisons = 0;
  int shk = 0, cvk = 0, cyc = 0, wk = 0, n_busy = 0, n_dma = 0, b = 0, w0 = 0;
  logic rd_d = 1'b0, cv_d = 1'b0, busy_d = 1'b0;
  logic [2:0] ch_s;
  logic [31:0] exp_q[$]; // expected read data, oldest first
  string nam_q[$];
  logic [31:0] e_w; // popped once, so a mismatch report shows the same note
  string n_w;
  sarsq_ph_s ph_q[$]; // expected conversion phases, oldest first
  sarsq_ph_s ph;
  logic [6:0] sel;
  always #12.5 core_clk = ~core_clk;
  sarsq_ctrl u_sarsq_ctrl (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .timer_waveform_output(timer_waveform_output), .ext_trigger(ext_trigger),
    .cell_power_on(cell_power_on), .cell_clk_en(cell_clk_en), .conv_tick(conv_tick),
    .cell_channel(cell_channel), .cell_sample(cell_sample), .cell_convert(cell_convert),
    .cell_result(cell_result), .dma_req(dma_req), .dma_size_8bit(dma_size_8bit), .irq(irq));
  sarsq_cell_model u_sarsq_cell_model (.core_clk(core_clk), .cell_convert(cell_convert),
    .cell_channel(cell_channel), .seed(sv), .cell_result(cell_result));
  // read data stands only in the cycle after the strobe: compare it there
  always @(posedge core_clk) begin
    if (rd_d === 1'b1) begin
      e_w = exp_q.pop_front();
      n_w = nam_q.pop_front();
      `CHK(n_w, e_w, reg_rdata)
    end
    rd_d <= reg_read;
  end
  // phase watcher: ticks per phase, cycles of conversion, channel order
  always @(posedge core_clk) begin
    if (cell_clk_en === 1'b1 && busy_d !== 1'b1) n_busy++;
    if (dma_req === 1'b1) n_dma++;
    if (cell_convert === 1'b1) begin
      cyc++;
      ch_s = cell_channel;
    end
    if (conv_tick === 1'b1) begin
      if (cell_sample === 1'b1) shk++;
      else if (cell_convert === 1'b1) cvk++;
      else if (cell_clk_en === 1'b1) wk++;
    end
    if (cv_d === 1'b1 && cell_convert !== 1'b1) begin
      if (ph_q.size() == 0) `CHK("extra conversion", 1'b0, 1'b1)
      else begin
        ph = ph_q.pop_front();
        `CHK("channel", ph.ch, ch_s)
        `CHK("hold ticks", ph.shk, shk[7:0])
        `CHK("conv ticks", 8'h0A, cvk[7:0])
        `CHK("conv cycles", ph.cyc, cyc[15:0])
      end
      shk = 0;
      cvk = 0;
      cyc = 0;
    end
    busy_d = cell_clk_en;
    cv_d = cell_convert;
  end
  // write strobe for one cycle, then a free cycle so strobes never collide
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
    @(posedge core_clk);
  endtask
  // the expected word is noted before the strobe goes out
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    exp_q.push_back(e);
    nam_q.push_back(n);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    @(posedge core_clk);
  endtask
  // wait for a sequence to start and finish, bounded
  task automatic seq_wait;
    int n;
    n = 0;
    while (cell_clk_en !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    while (cell_clk_en !== 1'b0 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    `CHK("sequence end", 1'b1, n < 3000)
    repeat (3) @(posedge core_clk);
  endtask
  // timer lines behave as waveform outputs: clean rising edges only
  task automatic pulse(input logic [6:0] m);
    timer_waveform_output <= m[5:0];
    ext_trigger <= m[6];
    repeat (4) @(posedge core_clk);
    timer_waveform_output <= 6'h00;
    ext_trigger <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // watchdog: the whole run needs well under 10000 cycles
  initial begin
    repeat (60000) @(posedge core_clk);
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rd(`SARSQ_OFS_CFG, 32'h00000000, "config");
    rd(`SARSQ_OFS_CHSTAT, 32'h00000000, "enable state");
    rd(8'h08, 32'h00000000, "unmapped");
    $display("reset values done");
    wr(`SARSQ_OFS_CHEN, 32'h000000A5);
    wr(`SARSQ_OFS_CHDIS, 32'h00000021);
    rd(`SARSQ_OFS_CHSTAT, 32'h00000084, "enable state");
    $display("channel enable done");
    // two channels, divider 1, hold field 2; channels kept fixed while busy
    sv <= 7'($random(seed));
    wr(`SARSQ_OFS_CFG, 32'h02000100);
    ph_q.push_back({3'h2, 8'h03, 16'h0028});
    ph_q.push_back({3'h7, 8'h03, 16'h0028});
    wr(`SARSQ_OFS_CMD, 32'h00000002);
    seq_wait();
    wr(`SARSQ_OFS_IEN, 32'h00010000);
    @(negedge core_clk);
    `CHK("irq on", 1'b1, irq)
    wr(`SARSQ_OFS_IDIS, 32'h00010000);
    @(negedge core_clk);
    `CHK("irq off", 1'b0, irq)
    rd(`SARSQ_OFS_FLAGS, 32'h00030084, "status");
    rd(`SARSQ_OFS_LAST, {22'h0, 3'h7, sv}, "last result");
    rd(`SARSQ_OFS_FLAGS, 32'h00000004, "status");
    rd(`SARSQ_OFS_CDR0 + 8'h08, {22'h0, 3'h2, sv}, "data 2");
    rd(`SARSQ_OFS_CDR0 + 8'h1C, {22'h0, 3'h7, sv}, "data 7");
    `CHK("dma count", 1, n_dma)
    `CHK("dma size", 1'b0, dma_size_8bit)
    $display("software sequence done");
    // low resolution, two sequences with nothing read in between
    wr(`SARSQ_OFS_CFG, 32'h00000010);
    repeat (2) begin
      ph_q.push_back({3'h2, 8'h01, 16'h0014});
      ph_q.push_back({3'h7, 8'h01, 16'h0014});
      sv <= 7'($random(seed));
      wr(`SARSQ_OFS_CMD, 32'h00000002);
      seq_wait();
    end
    c = {3'h2, sv};
    rd(`SARSQ_OFS_FLAGS, 32'h00038484, "status");
    rd(`SARSQ_OFS_CDR0 + 8'h08, {24'h0, c[9:2]}, "data 2 low");
    `CHK("dma count", 2, n_dma)
    `CHK("dma size", 1'b1, dma_size_8bit)
    $display("overrun and low resolution done");
    wr(`SARSQ_OFS_CHDIS, 32'h000000FF);
    wr(`SARSQ_OFS_CHEN, 32'h00000001);
    for (int k = 0; k < 7; k++) begin
      sel = (k < 6) ? (7'h01 << k) : 7'h40;
      wr(`SARSQ_OFS_CFG, 32'h00000001 | (32'(k) << 1));
      b = n_busy;
      pulse(~sel);
      `CHK("unselected trigger", b, n_busy)
      ph_q.push_back({3'h0, 8'h01, 16'h0014});
      pulse(sel);
      seq_wait();
      `CHK("selected trigger", b + 1, n_busy)
    end
    wr(`SARSQ_OFS_CFG, 32'h0000000C);
    b = n_busy;
    pulse(7'h40);
    `CHK("trigger disabled", b, n_busy)
    // normal mode keeps one start that arrives while busy and runs it next
    b = n_busy;
    ph_q.push_back({3'h0, 8'h01, 16'h0014});
    ph_q.push_back({3'h0, 8'h01, 16'h0014});
    wr(`SARSQ_OFS_CMD, 32'h00000002);
    wr(`SARSQ_OFS_CMD, 32'h00000002);
    seq_wait();
    seq_wait();
    `CHK("pending start", b + 2, n_busy)
    $display("hardware trigger done");
    // sleep, hardware trigger armed, software start still accepted
    wr(`SARSQ_OFS_CFG, 32'h0000002D);
    @(negedge core_clk);
    `CHK("sleep power", 1'b0, cell_power_on)
    b = n_busy;
    w0 = wk;
    ph_q.push_back({3'h0, 8'h01, 16'h0014});
    wr(`SARSQ_OFS_CMD, 32'h00000002);
    repeat (6) @(posedge core_clk);
    wr(`SARSQ_OFS_CMD, 32'h00000002);
    seq_wait();
    `CHK("sleep starts", b + 1, n_busy)
    `CHK("wake ticks", 8, wk - w0)
    @(negedge core_clk);
    `CHK("sleep power", 1'b0, cell_power_on)
    `CHK("phases left", 0, ph_q.size())
    $display("sleep sequence done");
    // software reset while idle: mode word and enable state back to defaults
    wr(`SARSQ_OFS_CMD, 32'h00000001);
    rd(`SARSQ_OFS_CFG, 32'h00000000, "config after reset");
    rd(`SARSQ_OFS_CHSTAT, 32'h00000000, "enable after reset");
    $display("software reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
